// File: hdl/pcsr_regs.vh
// Purpose : offsets, field positions and reset values for pcsr
// Assumes : 32-bit register port, byte offsets
// Notes   : included by pcsr_top.v only
`ifndef PCSR_REGS_VH
`define PCSR_REGS_VH

// register offsets
`define PCSR_OFS_SEQ_STATUS    8'h24
`define PCSR_OFS_CONV_CTRL     8'h2c
`define PCSR_OFS_SUPPLY_STATUS 8'h30
`define PCSR_OFS_CORE_LEVEL    8'h34
`define PCSR_OFS_PLL_LEVEL     8'h40
`define PCSR_OFS_SLEEP1_DWELL  8'h44
`define PCSR_OFS_SLEEP2_DWELL  8'h48
`define PCSR_OFS_IRQ_STATUS    8'h4c
`define PCSR_OFS_IRQ_MASK      8'h50

// sequence status fields
`define PCSR_SEQ_PREV_IO       29
`define PCSR_SEQ_PREV_PLL      28
`define PCSR_SEQ_PREV_ANA      25
`define PCSR_SEQ_PREV_CORE     24
`define PCSR_SEQ_STATE_LSB     16
`define PCSR_CFG_CLK_DIS       14
`define PCSR_CFG_ANA_MOD       9
`define PCSR_CFG_CORE_MOD      8
`define PCSR_CFG_IO_EN         5
`define PCSR_CFG_PLL_EN        4
`define PCSR_CFG_ANA_EN        1
`define PCSR_CFG_CORE_EN       0
`define PCSR_PREV_RST          4'b0010

// converter control fields
`define PCSR_CC_PGOOD_LSB      24
`define PCSR_CC_ERR_CLR        16
`define PCSR_CC_ANA_ILIM_LSB   13
`define PCSR_CC_ANA_CLK_LSB    8
`define PCSR_CC_CORE_ILIM_LSB  5
`define PCSR_CC_CORE_CLK_LSB   0
`define PCSR_PGOOD_RST         2'h2
`define PCSR_ILIM_RST          2'h0
`define PCSR_SWCLK_RST         2'h1

// supply status fields
`define PCSR_SS_OSC_OK         24
`define PCSR_SS_PLL_OK         19
`define PCSR_SS_CORE_OK        16
`define PCSR_SS_ANA_ILIM       9
`define PCSR_SS_CORE_ILIM      8
`define PCSR_SS_ANA_SOFT       1
`define PCSR_SS_CORE_SOFT      0

// dwell field and its reset
`define PCSR_DWELL_LSB         16
`define PCSR_DWELL_RST         5'h10

// interrupt status bits
`define PCSR_IRQ_STATE_CHG     0
`define PCSR_IRQ_CORE_LOST     1
`define PCSR_IRQ_PLL_LOST      2
`define PCSR_IRQ_ILIM          3
`define PCSR_IRQ_W             4

`endif

// File: hdl/pcsr_top.v
// Purpose : status and configuration registers of the power control block
// Assumes : single 250 MHz clock, strap and analog status inputs synchronous
// Notes   : sequencer itself lives outside; dwell counts exported to it
//
// How it works
// - state code readable, three bits, read-only
// - previous-state enables readable, reset 0,0,1,0
// - live supply configuration mirrored read-only
// - power-good threshold field, reset code 2
// - error clear bit held until software clears
// - analog converter current limit, reset 0
// - analog converter switching clock, reset 1
// - core converter current limit, reset 0
// - core converter switching clock, reset 1
// - oscillator, pll rail, core rail good flags
// - current-limit and soft-start flags per converter
// - core level seven bits, reset from straps
// - pll level three bits, reset from straps
// - sleeping dwell log2 count, reset 16
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pcsr_regs.vh"

module pcsr_top (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        rstn_i,
    // register port
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    // sequencer view
    input  wire [2:0]  seq_state_i,
    input  wire        cfg_clk_dis_i,
    input  wire        cfg_ana_mod_i,
    input  wire        cfg_core_mod_i,
    input  wire        cfg_io_supply_output_en_i,
    input  wire        cfg_pll_regulator_en_i,
    input  wire        cfg_analog_converter_en_i,
    input  wire        cfg_core_converter_en_i,
    // analog health
    input  wire        osc_stable_i,
    input  wire        pll_supply_rail_good_i,
    input  wire        core_rail_good_i,
    input  wire        analog_converter_ilim_i,
    input  wire        core_converter_ilim_i,
    input  wire        analog_converter_soft_i,
    input  wire        core_converter_soft_i,
    // boot straps
    input  wire [6:0]  strap_core_level_i,
    input  wire [2:0]  strap_pll_level_i,
    // converter settings out
    output reg  [1:0]  pgood_thresh_o,
    output reg         conv_err_clr_o,
    output reg  [1:0]  analog_converter_ilim_sel_o,
    output reg  [1:0]  analog_converter_clk_sel_o,
    output reg  [1:0]  core_converter_ilim_sel_o,
    output reg  [1:0]  core_converter_clk_sel_o,
    output reg  [6:0]  core_rail_level_o,
    output reg  [2:0]  pll_regulator_level_o,
    output reg  [4:0]  sleep1_dwell_log2_o,
    output reg  [4:0]  sleep2_dwell_log2_o,
    // interrupt
    output reg         irq_o
);

    //------------------------------------------------------------
    // decode helpers
    //------------------------------------------------------------
    function hit;
        input [7:0] a;
        input [7:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire wr_cc    = reg_wr_i & hit(reg_addr_i, `PCSR_OFS_CONV_CTRL);
    wire wr_core  = reg_wr_i & hit(reg_addr_i, `PCSR_OFS_CORE_LEVEL);
    wire wr_pll   = reg_wr_i & hit(reg_addr_i, `PCSR_OFS_PLL_LEVEL);
    wire wr_s1    = reg_wr_i & hit(reg_addr_i, `PCSR_OFS_SLEEP1_DWELL);
    wire wr_s2    = reg_wr_i & hit(reg_addr_i, `PCSR_OFS_SLEEP2_DWELL);
    wire wr_ist   = reg_wr_i & hit(reg_addr_i, `PCSR_OFS_IRQ_STATUS);
    wire wr_imsk  = reg_wr_i & hit(reg_addr_i, `PCSR_OFS_IRQ_MASK);

    //------------------------------------------------------------
    // previous-state enable tracking
    //------------------------------------------------------------
    reg  [2:0] state_q;
    reg  [3:0] cur_en_q;
    reg  [3:0] prev_en_q;
    reg        strap_pend_q;
    wire [3:0] live_en = {cfg_io_supply_output_en_i, cfg_pll_regulator_en_i,
                          cfg_analog_converter_en_i, cfg_core_converter_en_i};
    wire       state_chg = (seq_state_i != state_q);

    // on each state change the enables in force become previous
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q   <= 3'h0;
            cur_en_q  <= `PCSR_PREV_RST;
            prev_en_q <= `PCSR_PREV_RST;
        end else begin
            state_q  <= seq_state_i;
            cur_en_q <= live_en;
            if (state_chg) begin
                prev_en_q <= cur_en_q;
            end
        end
    end

    //------------------------------------------------------------
    // writable control registers
    //------------------------------------------------------------
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pgood_thresh_o              <= `PCSR_PGOOD_RST;
            conv_err_clr_o              <= 1'b0;
            analog_converter_ilim_sel_o <= `PCSR_ILIM_RST;
            analog_converter_clk_sel_o  <= `PCSR_SWCLK_RST;
            core_converter_ilim_sel_o   <= `PCSR_ILIM_RST;
            core_converter_clk_sel_o    <= `PCSR_SWCLK_RST;
            sleep1_dwell_log2_o         <= `PCSR_DWELL_RST;
            sleep2_dwell_log2_o         <= `PCSR_DWELL_RST;
            core_rail_level_o           <= 7'h00;
            pll_regulator_level_o       <= 3'h0;
            strap_pend_q                <= 1'b1;
        end else begin
            // straps caught on the first edge after release
            strap_pend_q <= 1'b0;
            if (strap_pend_q) begin
                core_rail_level_o     <= strap_core_level_i;
                pll_regulator_level_o <= strap_pll_level_i;
            end else begin
                if (wr_core) begin
                    // slew pacing left to software
                    core_rail_level_o <= reg_wdata_i[6:0];
                end
                if (wr_pll) begin
                    // single-code steps left to software
                    pll_regulator_level_o <= reg_wdata_i[2:0];
                end
            end
            if (wr_cc) begin
                pgood_thresh_o <= reg_wdata_i[`PCSR_CC_PGOOD_LSB+1:`PCSR_CC_PGOOD_LSB];
                conv_err_clr_o <= reg_wdata_i[`PCSR_CC_ERR_CLR];
                analog_converter_ilim_sel_o <=
                    reg_wdata_i[`PCSR_CC_ANA_ILIM_LSB+1:`PCSR_CC_ANA_ILIM_LSB];
                analog_converter_clk_sel_o <=
                    reg_wdata_i[`PCSR_CC_ANA_CLK_LSB+1:`PCSR_CC_ANA_CLK_LSB];
                core_converter_ilim_sel_o <=
                    reg_wdata_i[`PCSR_CC_CORE_ILIM_LSB+1:`PCSR_CC_CORE_ILIM_LSB];
                core_converter_clk_sel_o <=
                    reg_wdata_i[`PCSR_CC_CORE_CLK_LSB+1:`PCSR_CC_CORE_CLK_LSB];
            end
            if (wr_s1) begin
                sleep1_dwell_log2_o <= reg_wdata_i[`PCSR_DWELL_LSB+4:`PCSR_DWELL_LSB];
            end
            if (wr_s2) begin
                sleep2_dwell_log2_o <= reg_wdata_i[`PCSR_DWELL_LSB+4:`PCSR_DWELL_LSB];
            end
        end
    end

    //------------------------------------------------------------
    // interrupts
    //------------------------------------------------------------
    reg  [`PCSR_IRQ_W-1:0] irq_st_q;
    reg  [`PCSR_IRQ_W-1:0] irq_msk_q;
    reg                    core_ok_q;
    reg                    pll_ok_q;
    wire [`PCSR_IRQ_W-1:0] irq_ev;

    assign irq_ev[`PCSR_IRQ_STATE_CHG] = state_chg;
    assign irq_ev[`PCSR_IRQ_CORE_LOST] = core_ok_q & ~core_rail_good_i;
    assign irq_ev[`PCSR_IRQ_PLL_LOST]  = pll_ok_q & ~pll_supply_rail_good_i;
    assign irq_ev[`PCSR_IRQ_ILIM]      = analog_converter_ilim_i | core_converter_ilim_i;

    // sticky bits, set wins over write-one-to-clear
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_st_q  <= {`PCSR_IRQ_W{1'b0}};
            irq_msk_q <= {`PCSR_IRQ_W{1'b0}};
            core_ok_q <= 1'b0;
            pll_ok_q  <= 1'b0;
            irq_o     <= 1'b0;
        end else begin
            core_ok_q <= core_rail_good_i;
            pll_ok_q  <= pll_supply_rail_good_i;
            irq_st_q  <= (irq_st_q & ~(wr_ist ? reg_wdata_i[`PCSR_IRQ_W-1:0]
                                              : {`PCSR_IRQ_W{1'b0}})) | irq_ev;
            if (wr_imsk) begin
                irq_msk_q <= reg_wdata_i[`PCSR_IRQ_W-1:0];
            end
            irq_o <= |(irq_st_q & irq_msk_q);
        end
    end

    //------------------------------------------------------------
    // read mux, data one cycle after strobe
    //------------------------------------------------------------
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;  // reserved and unmapped read zero
        case (reg_addr_i)
            `PCSR_OFS_SEQ_STATUS: begin
                rd_d[`PCSR_SEQ_PREV_IO]   = prev_en_q[3];
                rd_d[`PCSR_SEQ_PREV_PLL]  = prev_en_q[2];
                rd_d[`PCSR_SEQ_PREV_ANA]  = prev_en_q[1];
                rd_d[`PCSR_SEQ_PREV_CORE] = prev_en_q[0];
                rd_d[`PCSR_SEQ_STATE_LSB+2:`PCSR_SEQ_STATE_LSB] = state_q;
                rd_d[`PCSR_CFG_CLK_DIS]   = cfg_clk_dis_i;
                rd_d[`PCSR_CFG_ANA_MOD]   = cfg_ana_mod_i;
                rd_d[`PCSR_CFG_CORE_MOD]  = cfg_core_mod_i;
                rd_d[`PCSR_CFG_IO_EN]     = live_en[3];
                rd_d[`PCSR_CFG_PLL_EN]    = live_en[2];
                rd_d[`PCSR_CFG_ANA_EN]    = live_en[1];
                rd_d[`PCSR_CFG_CORE_EN]   = live_en[0];
            end
            `PCSR_OFS_CONV_CTRL: begin
                rd_d[`PCSR_CC_PGOOD_LSB+1:`PCSR_CC_PGOOD_LSB]         = pgood_thresh_o;
                rd_d[`PCSR_CC_ERR_CLR]                                = conv_err_clr_o;
                rd_d[`PCSR_CC_ANA_ILIM_LSB+1:`PCSR_CC_ANA_ILIM_LSB]   = analog_converter_ilim_sel_o;
                rd_d[`PCSR_CC_ANA_CLK_LSB+1:`PCSR_CC_ANA_CLK_LSB]     = analog_converter_clk_sel_o;
                rd_d[`PCSR_CC_CORE_ILIM_LSB+1:`PCSR_CC_CORE_ILIM_LSB] = core_converter_ilim_sel_o;
                rd_d[`PCSR_CC_CORE_CLK_LSB+1:`PCSR_CC_CORE_CLK_LSB]   = core_converter_clk_sel_o;
            end
            `PCSR_OFS_SUPPLY_STATUS: begin
                rd_d[`PCSR_SS_OSC_OK]    = osc_stable_i;
                rd_d[`PCSR_SS_PLL_OK]    = pll_supply_rail_good_i;
                rd_d[`PCSR_SS_CORE_OK]   = core_rail_good_i;
                rd_d[`PCSR_SS_ANA_ILIM]  = analog_converter_ilim_i;
                rd_d[`PCSR_SS_CORE_ILIM] = core_converter_ilim_i;
                rd_d[`PCSR_SS_ANA_SOFT]  = analog_converter_soft_i;
                rd_d[`PCSR_SS_CORE_SOFT] = core_converter_soft_i;
            end
            `PCSR_OFS_CORE_LEVEL:   rd_d[6:0] = core_rail_level_o;
            `PCSR_OFS_PLL_LEVEL:    rd_d[2:0] = pll_regulator_level_o;
            `PCSR_OFS_SLEEP1_DWELL: rd_d[`PCSR_DWELL_LSB+4:`PCSR_DWELL_LSB] = sleep1_dwell_log2_o;
            `PCSR_OFS_SLEEP2_DWELL: rd_d[`PCSR_DWELL_LSB+4:`PCSR_DWELL_LSB] = sleep2_dwell_log2_o;
            `PCSR_OFS_IRQ_STATUS:   rd_d[`PCSR_IRQ_W-1:0] = irq_st_q;
            `PCSR_OFS_IRQ_MASK:     rd_d[`PCSR_IRQ_W-1:0] = irq_msk_q;
            default:                rd_d = 32'h0000_0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_d : 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// File: tb/pcsr_assertions.sv
// Purpose : port-level checks of the pcsr register block
// Assumes : one clock, asynchronous active-low reset
// Notes   : bound to every pcsr_top instance
`timescale 1ns/1ps
`default_nettype none
module pcsr_assertions (
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    // register port
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // sequencer and settings
    input wire logic [2:0]  seq_state_i,
    input wire logic [1:0]  pgood_thresh_o,
    input wire logic        conv_err_clr_o,
    input wire logic [1:0]  analog_converter_ilim_sel_o,
    input wire logic [1:0]  analog_converter_clk_sel_o,
    input wire logic [1:0]  core_converter_ilim_sel_o,
    input wire logic [1:0]  core_converter_clk_sel_o,
    input wire logic [6:0]  core_rail_level_o,
    input wire logic [2:0]  pll_regulator_level_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_rd_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped;
        reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_cc_read;
        reg_rd_i && reg_addr_i == 8'h2c |=> reg_rdata_o == {6'h0, $past(pgood_thresh_o),
            7'h0, $past(conv_err_clr_o), 1'b0, $past(analog_converter_ilim_sel_o), 3'h0,
            $past(analog_converter_clk_sel_o), 1'b0, $past(core_converter_ilim_sel_o), 3'h0,
            $past(core_converter_clk_sel_o)};
    endproperty
    a_cc_read: assert property (p_cc_read) else $error("control readback wrong");
    property p_cc_wr;
        reg_wr_i && reg_addr_i == 8'h2c |=> pgood_thresh_o == $past(reg_wdata_i[25:24])
            && conv_err_clr_o == $past(reg_wdata_i[16])
            && core_converter_ilim_sel_o == $past(reg_wdata_i[6:5]);
    endproperty
    a_cc_wr: assert property (p_cc_wr) else $error("control write lost");
    property p_cc_hold;
        !(reg_wr_i && reg_addr_i == 8'h2c) |=> $stable(conv_err_clr_o)
            && $stable(analog_converter_clk_sel_o) && $stable(core_converter_clk_sel_o);
    endproperty
    a_cc_hold: assert property (p_cc_hold) else $error("control changed unasked");
    property p_state_rd;
        reg_rd_i && reg_addr_i == 8'h24 |=> reg_rdata_o[18:16] == $past(seq_state_i, 2);
    endproperty
    a_state_rd: assert property (p_state_rd) else $error("state code wrong");
    property p_core_wr;
        reg_wr_i && reg_addr_i == 8'h34 |=> core_rail_level_o == $past(reg_wdata_i[6:0]);
    endproperty
    a_core_wr: assert property (p_core_wr) else $error("core level write lost");
    property p_pll_wr;
        reg_wr_i && reg_addr_i == 8'h40 |=> pll_regulator_level_o == $past(reg_wdata_i[2:0]);
    endproperty
    a_pll_wr: assert property (p_pll_wr) else $error("pll level write lost");
endmodule
bind pcsr_top pcsr_assertions u_chk (.ref_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .seq_state_i, .pgood_thresh_o, .conv_err_clr_o,
    .analog_converter_ilim_sel_o, .analog_converter_clk_sel_o, .core_converter_ilim_sel_o,
    .core_converter_clk_sel_o, .core_rail_level_o, .pll_regulator_level_o);
`default_nettype wire

// File: tb/pcsr_top_tb.sv
// Purpose : self-checking bench of the pcsr register block
// Assumes : register port answers the cycle after a read strobe
// Notes   : seed fixed at 10, so runs repeat
`timescale 1ns/1ps
`default_nettype none
module pcsr_top_tb;
    logic        ref_clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [2:0]  seq_state_i = 3'h0;
    logic [6:0]  cfg = 7'h00;      // clk dis, modes, io, pll, ana, core
    logic [2:0]  good = 3'h7;      // osc, pll rail, core rail
    logic [3:0]  stat = 4'h0;      // limits then soft-starts
    logic [6:0]  strap_core = 7'h00;
    logic [2:0]  strap_pll = 3'h0;
    logic [31:0] r;
    logic [6:0]  lv;
    wire  [31:0] rdata;
    wire  [1:0]  pg, ai, ac, ci, cc;
    wire         ec;
    wire         irq;
    wire  [6:0]  core_lvl;
    wire  [2:0]  pll_lvl;
    wire  [4:0]  dw1, dw2;
    integer      seed = 10;
    integer      n_mismatch = 0;
    integer      checks = 0;
    integer      i;
    logic [7:0]  bad_a [4] = '{8'h24, 8'h30, 8'h00, 8'hfc};

    // design under test
    pcsr_top DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata), .seq_state_i(seq_state_i), .cfg_clk_dis_i(cfg[6]),
        .cfg_ana_mod_i(cfg[5]), .cfg_core_mod_i(cfg[4]), .cfg_io_supply_output_en_i(cfg[3]),
        .cfg_pll_regulator_en_i(cfg[2]), .cfg_analog_converter_en_i(cfg[1]),
        .cfg_core_converter_en_i(cfg[0]), .osc_stable_i(good[2]),
        .pll_supply_rail_good_i(good[1]), .core_rail_good_i(good[0]),
        .analog_converter_ilim_i(stat[3]), .core_converter_ilim_i(stat[2]),
        .analog_converter_soft_i(stat[1]), .core_converter_soft_i(stat[0]),
        .strap_core_level_i(strap_core), .strap_pll_level_i(strap_pll),
        .pgood_thresh_o(pg), .conv_err_clr_o(ec), .analog_converter_ilim_sel_o(ai),
        .analog_converter_clk_sel_o(ac), .core_converter_ilim_sel_o(ci),
        .core_converter_clk_sel_o(cc), .core_rail_level_o(core_lvl),
        .pll_regulator_level_o(pll_lvl), .sleep1_dwell_log2_o(dw1),
        .sleep2_dwell_log2_o(dw2), .irq_o(irq));

    // 250 MHz clock
    always #2 ref_clk_i = ~ref_clk_i;

    // sequence status word from previous enables, state and live config
    function automatic logic [31:0] seq_exp(input logic [6:0] p, input logic [2:0] s,
                                            input logic [6:0] c);
        seq_exp = {2'h0, p[3], p[2], 2'h0, p[1], p[0], 5'h00, s, 1'b0, c[6], 4'h0,
                   c[5], c[4], 2'h0, c[3], c[2], 2'h0, c[1], c[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, settled outputs on return
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    // one-cycle read strobe, data compared in the following cycle
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #100000;
        n_mismatch++;
        stop_test;
    end

    initial begin
        r = $random(seed);
        strap_core = {1'b0, r[5:0]};
        strap_pll = r[10:8];
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        // reset values
        rdc(8'h2c, 32'h0200_0101);
        chk({pg, ec, ai, ac, ci, cc}, {2'h2, 1'b0, 2'h0, 2'h1, 2'h0, 2'h1});
        rdc(8'h24, 32'h0200_0000);
        rdc(8'h34, {25'h0, strap_core});
        rdc(8'h40, {29'h0, strap_pll});
        rdc(8'h44, 32'h0010_0000);
        rdc(8'h48, 32'h0010_0000);
        chk({dw1, dw2}, {5'h10, 5'h10});
        // converter control, all ones first
        for (i = 0; i < 16; i++) begin
            r = (i == 0) ? 32'hffff_ffff : $random(seed);
            wr(8'h2c, r);
            rdc(8'h2c, r & 32'h0301_6363);
            chk({pg, ec, ai, ac, ci, cc}, {r[25:24], r[16], r[14:13], r[9:8], r[6:5], r[1:0]});
        end
        // read-only and unmapped places ignore writes
        for (i = 0; i < 4; i++) begin
            wr(bad_a[i], 32'h0000_0000);
        end
        rdc(8'h2c, r & 32'h0301_6363);
        rdc(8'h00, 32'h0000_0000);
        // pll level raised one code per write
        for (i = 0; i < 8; i++) begin
            wr(8'h40, {{29{1'b1}}, i[2:0]});
            rdc(8'h40, {29'h0, i[2:0]});
            chk(pll_lvl, i[2:0]);
        end
        // core level one code per microsecond
        for (i = 1; i < 4; i++) begin
            lv = strap_core + i[6:0];
            wr(8'h34, {{25{1'b1}}, lv});
            rdc(8'h34, {25'h0, lv});
            chk(core_lvl, lv);
            repeat (250) @(posedge ref_clk_i);
        end
        // state walk through every code, enables change after each step
        wr(8'h50, 32'h0000_0001);
        for (i = 1; i < 9; i++) begin
            r = $random(seed);
            @(posedge ref_clk_i);
            cfg <= r[6:0];
            repeat (2) @(posedge ref_clk_i);
            seq_state_i <= i[2:0];
            @(posedge ref_clk_i);
            cfg <= r[14:8];
            rdc(8'h24, seq_exp(r[6:0], i[2:0], r[14:8]));
        end
        // state-change interrupt, masking and clearing
        chk(irq, 1'b1);
        rdc(8'h4c, 32'h0000_0001);
        wr(8'h50, 32'h0000_0000);
        @(posedge ref_clk_i);
        #1;
        chk(irq, 1'b0);
        wr(8'h4c, 32'h0000_0001);
        wr(8'h50, 32'h0000_0001);
        rdc(8'h4c, 32'h0000_0000);
        chk(irq, 1'b0);
        // live supply flags
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            @(posedge ref_clk_i);
            good <= r[2:0];
            stat <= r[6:3];
            rdc(8'h30, {7'h0, r[2], 4'h0, r[1], 2'h0, r[0], 6'h0, r[6], r[5], 6'h0, r[4], r[3]});
        end
        // core rail loss sets its sticky bit alone
        @(posedge ref_clk_i);
        good <= 3'h7;
        stat <= 4'h0;
        repeat (2) @(posedge ref_clk_i);
        wr(8'h4c, 32'h0000_000f);
        rdc(8'h4c, 32'h0000_0000);
        @(posedge ref_clk_i);
        good <= 3'h6;
        rdc(8'h4c, 32'h0000_0002);
        stop_test;
    end
endmodule
`default_nettype wire
